// [hw/ccl_pkg.sv]
// package: register map, field positions and shared types of the comparator control logic
package ccl_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] CCL_OFS_CMP_CTRL = 8'h50;
    localparam logic [7:0] CCL_OFS_CONV_B = 8'h7b;
    localparam logic [7:0] CCL_OFS_PIN_DIS = 8'h7f;
    localparam logic [7:0] CCL_OFS_CONV_A = 8'h7a;
    localparam logic [7:0] CCL_OFS_CHAN_SEL = 8'h7c;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CCL_B_POWER_OFF = 7;
    localparam int CCL_B_BANDGAP = 6;
    localparam int CCL_B_RESULT = 5;
    localparam int CCL_B_IRQ_FLAG = 4;
    localparam int CCL_B_IRQ_EN = 3;
    localparam int CCL_B_CAPTURE = 2;
    localparam int CCL_B_MODE_HI = 1;
    localparam int CCL_B_MODE_LO = 0;
    localparam int CCL_B_MUX_EN = 6;
    localparam int CCL_B_CONV_EN = 7;
    localparam int CCL_B_NEG_OFF = 1;
    localparam int CCL_B_POS_OFF = 0;

    // ************************************************************
    // reset values and masks
    // ************************************************************
    localparam logic [7:0] CCL_RST_BYTE = 8'h00;
    localparam logic [7:0] CCL_CONV_B_MASK = 8'h47;
    localparam logic [7:0] CCL_PIN_DIS_MASK = 8'h03;
    localparam logic [7:0] CCL_CHAN_SEL_MASK = 8'h07;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        CCL_MODE_TOGGLE = 2'b00,
        CCL_MODE_RESERVED = 2'b01,
        CCL_MODE_FALL = 2'b10,
        CCL_MODE_RISE = 2'b11
    } ccl_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ccl_bus_req_t;

    typedef struct packed {
        logic bandgap_sel;
        logic neg_from_channel;
        logic [2:0] channel;
        logic power_off;
    } ccl_analog_ctrl_t;

endpackage : ccl_pkg

// [hw/ccl_sync.sv]
// two-stage synchroniser for one level
module ccl_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    // reset state is a constant; first stage feeds only the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : ccl_sync

// [hw/ccl_top.sv]
// comparator control logic: registers, input selection, result sync, events
//
// How it works
// - result is high when selected positive input exceeds selected negative input
// - mux enable set, converter off: channel select picks negative input channel
// - mux enable clear or converter on: dedicated negative pin is used
// - mux enable at bit 6 of control b; bits 7 and 5..3 read zero
// - power-off bit 7 switches comparator power off, settable any time
// - bandgap select bit 6 feeds bandgap to positive input, else pin
// - raw result passes a synchroniser before the read-only result bit
// - interrupt flag bit 4 sets on the event chosen by mode bits
// - flag clears when vector is taken or software writes one
// - request only while enable bit 3 and global enable are both one
// - capture-routing bit 2 connects result to timer capture front end
// - capture-routing clear keeps result away from timer capture
// - mode 00 toggle, 10 falling, 11 rising, 01 reserved
// - timer noise canceler and edge select act on routed result
// - pin input disable bits turn buffers off; port bits read zero
// - disable register bits 7..2 read zero
// - converter enable bit 7 of control a, when clear, is the converter-off condition
module ccl_top #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic comparator_raw,
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    input wire logic positive_pin_digital,
    input wire logic negative_pin_digital,
    output logic comparator_irq_request,
    output logic capture_trigger,
    output logic capture_route_active,
    output logic bandgap_positive_select,
    output logic neg_from_channel,
    output logic [2:0] channel_select,
    output logic comparator_power_off,
    output logic positive_pin_port_bit,
    output logic negative_pin_port_bit,
    output logic positive_pin_buffer_off,
    output logic negative_pin_buffer_off
);

    // elaboration check: the synchroniser is fixed at two stages
    if (SYNC_STAGES != 2) begin : g_bad_stages
        $error("ccl_top: only a two-stage synchroniser is supported");
    end

    // ************************************************************
    // registers
    // ************************************************************
    ccl_pkg::ccl_bus_req_t req;
    logic [7:0] cmp_ctrl_q;
    logic [7:0] conv_b_q;
    logic [7:0] pin_dis_q;
    logic [7:0] conv_a_q;
    logic [7:0] chan_sel_q;
    logic irq_flag_q;
    logic result_sync;
    logic result_prev_q;
    logic event_hit;
    logic [7:0] rdata_q;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    function automatic logic hit(input ccl_pkg::ccl_bus_req_t r, input logic [7:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction : hit

    // writable control bits of the comparator register; flag and result live apart
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmp_ctrl_q <= ccl_pkg::CCL_RST_BYTE;
        end else if (hit(req, ccl_pkg::CCL_OFS_CMP_CTRL)) begin
            cmp_ctrl_q <= req.wdata;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            conv_b_q <= ccl_pkg::CCL_RST_BYTE;
        end else if (hit(req, ccl_pkg::CCL_OFS_CONV_B)) begin
            conv_b_q <= req.wdata & ccl_pkg::CCL_CONV_B_MASK;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_dis_q <= ccl_pkg::CCL_RST_BYTE;
        end else if (hit(req, ccl_pkg::CCL_OFS_PIN_DIS)) begin
            pin_dis_q <= req.wdata & ccl_pkg::CCL_PIN_DIS_MASK;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            conv_a_q <= ccl_pkg::CCL_RST_BYTE;
        end else if (hit(req, ccl_pkg::CCL_OFS_CONV_A)) begin
            conv_a_q <= req.wdata;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chan_sel_q <= ccl_pkg::CCL_RST_BYTE;
        end else if (hit(req, ccl_pkg::CCL_OFS_CHAN_SEL)) begin
            chan_sel_q <= req.wdata & ccl_pkg::CCL_CHAN_SEL_MASK;
        end
    end

    // ************************************************************
    // analog input selection
    // ************************************************************
    ccl_pkg::ccl_analog_ctrl_t actl;

    always_comb begin
        actl.bandgap_sel = cmp_ctrl_q[ccl_pkg::CCL_B_BANDGAP];
        actl.neg_from_channel = conv_b_q[ccl_pkg::CCL_B_MUX_EN]
            && !conv_a_q[ccl_pkg::CCL_B_CONV_EN];
        actl.channel = chan_sel_q[2:0];
        actl.power_off = cmp_ctrl_q[ccl_pkg::CCL_B_POWER_OFF];
    end

    assign bandgap_positive_select = actl.bandgap_sel;
    assign neg_from_channel = actl.neg_from_channel;
    assign channel_select = actl.channel;
    assign comparator_power_off = actl.power_off;

    // ************************************************************
    // result synchroniser and edge detection
    // ************************************************************
    // the core drives comparator_raw high when positive exceeds negative
    ccl_sync u_sync (
        .clk(clk),
        .reset(reset),
        .async_in(comparator_raw),
        .sync_out(result_sync)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_prev_q <= 1'b0;
        end else begin
            result_prev_q <= result_sync;
        end
    end

    // event match per mode
    always_comb begin
        unique case (ccl_pkg::ccl_mode_t'(cmp_ctrl_q[ccl_pkg::CCL_B_MODE_HI:ccl_pkg::CCL_B_MODE_LO]))
            ccl_pkg::CCL_MODE_TOGGLE: event_hit = result_sync != result_prev_q;
            ccl_pkg::CCL_MODE_RESERVED: event_hit = 1'b0;
            ccl_pkg::CCL_MODE_FALL: event_hit = !result_sync && result_prev_q;
            ccl_pkg::CCL_MODE_RISE: event_hit = result_sync && !result_prev_q;
        endcase
    end

    // ************************************************************
    // interrupt flag and request
    // ************************************************************
    // set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_flag_q <= 1'b0;
        end else if (event_hit) begin
            irq_flag_q <= 1'b1;
        end else if (irq_vector_taken
            || (hit(req, ccl_pkg::CCL_OFS_CMP_CTRL) && req.wdata[ccl_pkg::CCL_B_IRQ_FLAG])) begin
            irq_flag_q <= 1'b0;
        end
    end

    assign comparator_irq_request = irq_flag_q && cmp_ctrl_q[ccl_pkg::CCL_B_IRQ_EN]
        && global_irq_enable;

    // ************************************************************
    // timer capture routing
    // ************************************************************
    // timer front end applies its own noise canceler and edge select
    assign capture_route_active = cmp_ctrl_q[ccl_pkg::CCL_B_CAPTURE];
    assign capture_trigger = capture_route_active && result_sync;

    // ************************************************************
    // pin input buffers
    // ************************************************************
    assign positive_pin_buffer_off = pin_dis_q[ccl_pkg::CCL_B_POS_OFF];
    assign negative_pin_buffer_off = pin_dis_q[ccl_pkg::CCL_B_NEG_OFF];
    assign positive_pin_port_bit = positive_pin_digital && !positive_pin_buffer_off;
    assign negative_pin_port_bit = negative_pin_digital && !negative_pin_buffer_off;

    // ************************************************************
    // read path
    // ************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= ccl_pkg::CCL_RST_BYTE;
        end else if (req.rd) begin
            unique case (req.addr)
                ccl_pkg::CCL_OFS_CMP_CTRL: begin
                    rdata_q <= cmp_ctrl_q;
                    rdata_q[ccl_pkg::CCL_B_RESULT] <= result_sync;
                    rdata_q[ccl_pkg::CCL_B_IRQ_FLAG] <= irq_flag_q;
                end
                ccl_pkg::CCL_OFS_CONV_B: rdata_q <= conv_b_q;
                ccl_pkg::CCL_OFS_PIN_DIS: rdata_q <= pin_dis_q;
                ccl_pkg::CCL_OFS_CONV_A: rdata_q <= conv_a_q;
                ccl_pkg::CCL_OFS_CHAN_SEL: rdata_q <= chan_sel_q;
                default: rdata_q <= ccl_pkg::CCL_RST_BYTE;
            endcase
        end else begin
            rdata_q <= ccl_pkg::CCL_RST_BYTE;
        end
    end

    assign reg_rdata = rdata_q;

endmodule : ccl_top

// [verif/ccl_comparator_model.sv]
// analog comparator core model: input selection and compare
module ccl_comparator_model #(parameter logic [7:0] BANDGAP_LVL = 8'h96) (
    input wire ccl_pkg::ccl_analog_ctrl_t ctrl,
    input wire logic [7:0] pos_pin_lvl,
    input wire logic [7:0] neg_pin_lvl,
    input wire logic [63:0] chan_lvl,
    output logic comparator_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pos_lvl;
    logic [7:0] neg_lvl;
    assign pos_lvl = ctrl.bandgap_sel ? BANDGAP_LVL : pos_pin_lvl;
    assign neg_lvl = ctrl.neg_from_channel ? chan_lvl[{ctrl.channel, 3'h0} +: 8] : neg_pin_lvl;
    // powered off core gives a steady low
    assign comparator_raw = !ctrl.power_off && (pos_lvl > neg_lvl);
endmodule : ccl_comparator_model

// [verif/ccl_top_properties.sv]
// checker: port properties of the comparator control logic
module ccl_top_properties #(parameter int SYNC_STAGES = 2) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic global_irq_enable,
    input wire logic comparator_irq_request,
    input wire logic capture_trigger,
    input wire logic capture_route_active,
    input wire logic neg_from_channel,
    input wire logic [2:0] channel_select,
    input wire logic comparator_power_off,
    input wire logic positive_pin_port_bit,
    input wire logic positive_pin_buffer_off
);
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    chk_capture_off: assert property (!capture_route_active |-> !capture_trigger)
        else $error("capture trigger without routing");
    chk_global_gate: assert property (!global_irq_enable |-> !comparator_irq_request)
        else $error("request while globally masked");
    chk_mux_clear: assert property (reg_wr && reg_addr == 8'h7b && !reg_wdata[6] |=> !neg_from_channel)
        else $error("channel path after mux enable cleared");
    chk_conv_on: assert property (reg_wr && reg_addr == 8'h7a && reg_wdata[7] |=> !neg_from_channel)
        else $error("channel path with converter on");
    chk_chan_write: assert property (reg_wr && reg_addr == 8'h7c |=> {5'h00, channel_select} == ($past(reg_wdata) & 8'h07))
        else $error("channel select not stored");
    chk_power_set: assert property (reg_wr && reg_addr == 8'h50 && reg_wdata[7] |=> comparator_power_off)
        else $error("power off not applied");
    chk_port_gate: assert property (positive_pin_buffer_off |-> !positive_pin_port_bit)
        else $error("port bit high with buffer off");
    chk_pin_reserved: assert property (reg_rd && reg_addr == 8'h7f |=> reg_rdata[7:2] == 6'h00)
        else $error("pin disable reserved bits not zero");
    chk_convb_reserved: assert property (reg_rd && reg_addr == 8'h7b |=> (reg_rdata & 8'hb8) == 8'h00)
        else $error("control b reserved bits not zero");
    cover property (comparator_irq_request);
    cover property (capture_trigger);
    cover property (neg_from_channel && channel_select == 3'h7);
endmodule : ccl_top_properties

bind ccl_top ccl_top_properties #(.SYNC_STAGES(SYNC_STAGES)) u_props (.*);

// [verif/ccl_top_tb.sv]
// testbench: register, routing and event checks of the comparator control logic
module ccl_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] RISE_EXP = 4'h9;
    localparam logic [3:0] FALL_EXP = 4'h5;
    logic clk, reset, reg_wr, reg_rd, comparator_raw, global_irq_enable, irq_vector_taken;
    logic positive_pin_digital, negative_pin_digital, comparator_irq_request, capture_trigger;
    logic capture_route_active, bandgap_positive_select, neg_from_channel, comparator_power_off;
    logic positive_pin_port_bit, negative_pin_port_bit, positive_pin_buffer_off, negative_pin_buffer_off;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pos_lvl, neg_lvl, d;
    logic [2:0] channel_select;
    logic [63:0] chan_lvl;
    ccl_pkg::ccl_analog_ctrl_t actl;
    int fail_count, tests_run;
    ccl_top #(.SYNC_STAGES(2)) dut (.*);
    assign actl = {bandgap_positive_select, neg_from_channel, channel_select, comparator_power_off};
    ccl_comparator_model model (.ctrl(actl), .pos_pin_lvl(pos_lvl), .neg_pin_lvl(neg_lvl),
        .chan_lvl(chan_lvl), .comparator_raw(comparator_raw));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ************************************************************
    // bus tasks and checks
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cyc
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : check8
    task automatic summarize();
        $display("counts: compared %0d, failed %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        summarize();
    end
    initial begin
        {reset, global_irq_enable, positive_pin_digital, negative_pin_digital} = 4'hf;
        {reg_wr, reg_rd, irq_vector_taken, reg_addr, reg_wdata} = 19'h0;
        {pos_lvl, neg_lvl, chan_lvl} = {8'h64, 8'hc8, {8{8'hc8}}};
        fail_count = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(8'h50); check8(d, 8'h00);
        rd(8'h7b); check8(d, 8'h00);
        wr(8'h7b, 8'hff); rd(8'h7b); check8(d, 8'h47);
        wr(8'h7f, 8'hff); rd(8'h7f); check8(d, 8'h03);
        rd(8'h33); check8(d, 8'h00);
        wr(8'h7f, 8'h01); check8({6'h00, negative_pin_port_bit, positive_pin_port_bit}, 8'h02);
        wr(8'h7f, 8'h02); check8({6'h00, negative_pin_port_bit, positive_pin_port_bit}, 8'h01);
        wr(8'h7b, 8'h40);
        wr(8'h7a, 8'h00);
        for (int ch = 0; ch < 8; ch++) begin
            chan_lvl = {8{8'hc8}};
            chan_lvl[ch * 8 +: 8] = 8'h32;
            wr(8'h7c, 8'(ch));
            cyc(3); rd(8'h50); check8(d & 8'h20, 8'h20);
        end
        wr(8'h7a, 8'h80); cyc(3); rd(8'h50); check8(d & 8'h20, 8'h00);
        wr(8'h7a, 8'h00); wr(8'h7b, 8'h00); cyc(3); rd(8'h50); check8(d & 8'h20, 8'h00);
        neg_lvl = 8'h78;
        // result rises in toggle mode, so the flag is set beside it
        wr(8'h50, 8'h40); cyc(3); rd(8'h50); check8(d, 8'h70);
        wr(8'h50, 8'h50); rd(8'h50); check8(d, 8'h60);
        wr(8'h50, 8'h00);
        neg_lvl = 8'hc8;
        for (int m = 0; m < 4; m++) begin
            wr(8'h50, 8'h10 | 8'(m));
            wr(8'h50, 8'h08 | 8'(m));
            pos_lvl = 8'hfa;
            cyc(5); check8({7'h00, comparator_irq_request}, {7'h00, RISE_EXP[m]});
            @(posedge clk);
            irq_vector_taken <= 1'b1;
            @(posedge clk);
            irq_vector_taken <= 1'b0;
            cyc(0); check8({7'h00, comparator_irq_request}, 8'h00);
            pos_lvl = 8'h64;
            cyc(5); check8({7'h00, comparator_irq_request}, {7'h00, FALL_EXP[m]});
            if (m == 0) begin
                @(posedge clk);
                global_irq_enable <= 1'b0;
                cyc(0); check8({7'h00, comparator_irq_request}, 8'h00);
                @(posedge clk);
                global_irq_enable <= 1'b1;
            end
        end
        wr(8'h50, 8'h10);
        pos_lvl = 8'hfa;
        wr(8'h50, 8'h04); cyc(3); check8({7'h00, capture_trigger}, 8'h01);
        wr(8'h50, 8'h00); check8({7'h00, capture_trigger}, 8'h00);
        wr(8'h50, 8'h80); check8({7'h00, comparator_power_off}, 8'h01);
        // powered-off core pulls the result low: a toggle event sets the flag
        cyc(3); rd(8'h50); check8(d, 8'h90);
        summarize();
    end
endmodule : ccl_top_tb
